// *** hw/csw_pkg.sv ***
package csw_pkg;

    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [15:0] REG_MODE_SELECT  = 16'h2af8;
    localparam logic [15:0] REG_START_STOP   = 16'h2b02;
    localparam logic [15:0] REG_RUN_STATUS   = 16'h2b03;
    localparam logic [15:0] REG_ERROR_WORD   = 16'h2b04;
    localparam logic [15:0] REG_DWELL_MS     = 16'h2b05;
    localparam logic [15:0] REG_FIRST_INDEX  = 16'h2b06;
    localparam logic [15:0] REG_LAST_INDEX   = 16'h2b07;
    localparam logic [15:0] REG_EXTRA_CYCLES = 16'h2b08;
    localparam logic [15:0] CURVE_BASE       = 16'h2b5c;
    localparam logic [15:0] CURVE_LAST       = 16'h2bbf;
    localparam logic [15:0] RES_VOLT_BASE    = 16'h2bc0;
    localparam logic [15:0] RES_CURR_BASE    = 16'h2c24;
    localparam logic [15:0] RES_POW_BASE     = 16'h2c88;
    localparam logic [15:0] RES_LAST         = 16'h2ceb;

    // ------------------------------------------------------------
    // Command codes, limits, field positions
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_START   = 16'hff00;
    localparam logic [15:0] CMD_STOP    = 16'h0000;
    localparam logic [15:0] POINTS_MAX  = 16'h0064;
    localparam int          POINTS      = 100;
    localparam int          IDX_W       = 7;
    localparam int          ST_RUN_BIT  = 0;
    localparam int          ST_DONE_BIT = 1;
    localparam int          ST_ABRT_BIT = 2;
    localparam int          ER_MODE_BIT = 0;
    localparam int          ER_MEAS_BIT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_MODE   = 16'h0000;
    localparam logic [15:0] RST_DWELL  = 16'h0000;
    localparam logic [15:0] RST_FIRST  = 16'h0001;
    localparam logic [15:0] RST_LAST   = 16'h0001;
    localparam logic [15:0] RST_EXTRA  = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1000000;
    localparam int TICKS_PER_MS  = MS_NS / CLK_PERIOD_NS;
    localparam int MEAS_TO_NS    = 100000;
    localparam logic [15:0] MEAS_TO_CYC = 16'(MEAS_TO_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } csw_wr_s;

    typedef struct packed {
        logic [15:0] current;
        logic [15:0] power;
    } csw_meas_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_APPLY = 3'b011,
        ST_MEAS  = 3'b010,
        ST_DWELL = 3'b110
    } csw_state_e;

    typedef enum logic [1:0] {
        RK_REG   = 2'h0,
        RK_CURVE = 2'h1,
        RK_RES   = 2'h2
    } csw_rkind_e;

endpackage

// *** hw/csw_word_mem.sv ***
`timescale 1ns/1ps

module csw_word_mem
    import csw_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 100,
    parameter int AW    = 7
) (
    // Clock
    input  wire logic             mclk_i,
    // Write port
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Registered read port
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // No reset on the array; unloaded curve entries are masked by the caller, result entries are not
    always_ff @(posedge mclk_i) begin
        rdata_o <= mem[raddr_i];
    end

endmodule

// *** hw/csw_sweeper.sv ***
// What this block does
// RL1: Mode select must be user-curve mode before configuration or start is accepted.
// RL2: Host loads one curve voltage per point index; the block keeps them.
// RL3: A point whose voltage was never loaded is applied as zero volts.
// RL4: End index accepts values one to one hundred; it is the last point.
// RL5: Start index accepts only one up to the current end index.
// RL6: Host writes the end index before the start index.
// RL7: Interval register gives the dwell in milliseconds between points.
// RL8: Repetitions count extra cycles; zero runs the range once.
// RL9: Results hold only the last cycle, earlier cycles overwritten.
// RL10: Start applies first point voltage, measures, stores, then advances.
// RL11: Run ends by itself after interval times points times cycles.
// RL12: Stop written during the run aborts it at once.
// RL13: Status word shows whether the run is going or finished.
// RL14: Error word records run errors, readable during and after the run.
// RL15: Per-point results are readable in the result region.
// RL16: Sixteen-bit words; points ascend start to end, restart each cycle.
// RL17: Start register takes ff00 as start, zero as stop, else ignored.
`timescale 1ns/1ps

module csw_sweeper
    import csw_pkg::*;
#(
    parameter logic [15:0] MODE_CODE    = 16'h0001,
    parameter int          TICKS_MS_CYC = TICKS_PER_MS
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Host register port
    input  wire logic        wr_en_i,
    input  wire csw_wr_s     wr_i,
    input  wire logic        rd_en_i,
    input  wire logic [15:0] rd_addr_i,
    output logic      [15:0] rd_data_o,
    output logic             rd_valid_o,
    // Source and measurement
    output logic      [15:0] set_voltage_o,
    output logic             meas_req_o,
    input  wire logic        meas_valid_i,
    input  wire csw_meas_s   meas_i,
    output logic             sweep_active_o
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    csw_state_e       state;
    logic [15:0]      mode_sel;
    logic [15:0]      dwell_ms;
    logic [15:0]      range_first;
    logic [15:0]      range_last;
    logic [15:0]      extra_cycles;
    logic [15:0]      cyc_left;
    logic [15:0]      point;
    logic [15:0]      ms_cnt;
    logic [15:0]      tick_cnt;
    logic [15:0]      to_cnt;
    logic [2:0]       run_status;
    logic [1:0]       err_word;
    logic [POINTS-1:0] loaded;
    logic [15:0]      applied_v;

    logic             mode_ok;
    logic             running;
    logic             wr_start;
    logic             wr_stop;
    logic             dwell_done;
    logic             last_point;
    logic             meas_take;
    logic             meas_tmo;
    logic             curve_we;
    logic [15:0]      wr_off;
    logic [IDX_W-1:0] pt_idx;

    assign mode_ok    = (mode_sel == MODE_CODE);
    assign running    = (state != ST_IDLE);
    assign wr_start   = wr_en_i && wr_i.addr == REG_START_STOP && wr_i.data == CMD_START; // RL17
    assign wr_stop    = wr_en_i && wr_i.addr == REG_START_STOP && wr_i.data == CMD_STOP;  // RL17
    assign dwell_done = (state == ST_DWELL) && (ms_cnt == dwell_ms);
    assign last_point = (point == range_last);
    assign meas_take  = (state == ST_MEAS) && meas_valid_i;
    assign meas_tmo   = (state == ST_MEAS) && !meas_valid_i && (to_cnt == MEAS_TO_CYC);
    assign wr_off     = wr_i.addr - CURVE_BASE;
    assign pt_idx     = IDX_W'(point - 16'h0001);
    // Curve changes only while idle so a run sees a fixed table
    assign curve_we   = wr_en_i && mode_ok && !running
                        && wr_i.addr >= CURVE_BASE && wr_i.addr <= CURVE_LAST; // RL1 RL2

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_sel <= RST_MODE;
        end else if (wr_en_i && wr_i.addr == REG_MODE_SELECT && !running) begin
            mode_sel <= wr_i.data; // RL1
        end
    end

    // Changes are refused during a run; the sweep uses live values
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dwell_ms     <= RST_DWELL;
            range_first  <= RST_FIRST;
            range_last   <= RST_LAST;
            extra_cycles <= RST_EXTRA;
        end else if (wr_en_i && mode_ok && !running) begin // RL1
            case (wr_i.addr)
                REG_DWELL_MS: begin
                    dwell_ms <= wr_i.data; // RL7
                end
                REG_LAST_INDEX: begin
                    if (wr_i.data != 16'h0000 && wr_i.data <= POINTS_MAX) begin
                        range_last <= wr_i.data; // RL4
                        // Keep start not above end when the end is lowered
                        if (range_first > wr_i.data) begin
                            range_first <= wr_i.data; // RL5
                        end
                    end
                end
                REG_FIRST_INDEX: begin
                    if (wr_i.data != 16'h0000 && wr_i.data <= range_last) begin
                        range_first <= wr_i.data; // RL5 RL6
                    end
                end
                REG_EXTRA_CYCLES: begin
                    extra_cycles <= wr_i.data; // RL8
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            loaded <= '0;
        end else if (curve_we) begin
            loaded[IDX_W'(wr_off)] <= 1'b1; // RL2 RL3
        end
    end

    // ------------------------------------------------------------
    // Sweep sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state    <= ST_IDLE;
            point    <= RST_FIRST;
            cyc_left <= RST_EXTRA;
        end else if (running && wr_stop) begin
            state <= ST_IDLE; // RL12
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wr_start && mode_ok) begin
                        state    <= ST_FETCH; // RL10
                        point    <= range_first;
                        cyc_left <= extra_cycles; // RL8
                    end
                end
                ST_FETCH: begin
                    state <= ST_APPLY;
                end
                ST_APPLY: begin
                    state <= ST_MEAS;
                end
                ST_MEAS: begin
                    if (meas_valid_i || meas_tmo) begin
                        state <= ST_DWELL;
                    end
                end
                ST_DWELL: begin
                    if (dwell_done) begin // RL7
                        if (!last_point) begin
                            point <= point + 16'h0001; // RL16
                            state <= ST_FETCH;
                        end else if (cyc_left != 16'h0000) begin
                            cyc_left <= cyc_left - 16'h0001;
                            point    <= range_first; // RL16
                            state    <= ST_FETCH;
                        end else begin
                            state <= ST_IDLE; // RL11
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Millisecond base: one tick counter shared by the dwell
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt <= 16'h0000;
            ms_cnt   <= 16'h0000;
        end else if (state != ST_DWELL || dwell_done) begin
            tick_cnt <= 16'h0000;
            ms_cnt   <= 16'h0000;
        end else if (tick_cnt == 16'(TICKS_MS_CYC - 1)) begin
            tick_cnt <= 16'h0000;
            ms_cnt   <= ms_cnt + 16'h0001; // RL7
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            to_cnt <= 16'h0000;
        end else if (state == ST_MEAS) begin
            to_cnt <= to_cnt + 16'h0001;
        end else begin
            to_cnt <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Source drive and measurement request
    // ------------------------------------------------------------
    logic [15:0] curve_rdata;
    logic [15:0] res_rdata [3];
    logic [15:0] res_wdata [3];
    logic [IDX_W-1:0] host_idx;
    logic [IDX_W-1:0] curve_raddr;

    assign curve_raddr = running ? pt_idx : host_idx;

    csw_word_mem #(.WIDTH(16), .DEPTH(POINTS), .AW(IDX_W)) u_curve (
        .mclk_i  (mclk_i),
        .we_i    (curve_we),
        .waddr_i (IDX_W'(wr_off)),
        .wdata_i (wr_i.data),
        .raddr_i (curve_raddr),
        .rdata_o (curve_rdata)
    );

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            applied_v <= 16'h0000;
        end else if (state == ST_APPLY && !wr_stop) begin
            applied_v <= loaded[pt_idx] ? curve_rdata : 16'h0000; // RL3 RL10
        end else if (!running) begin
            applied_v <= 16'h0000;
        end
    end
    assign set_voltage_o = applied_v;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meas_req_o <= 1'b0;
        end else begin
            meas_req_o <= (state == ST_APPLY) && !(wr_stop); // RL10
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sweep_active_o <= 1'b0;
        end else if (running && wr_stop) begin
            sweep_active_o <= 1'b0; // RL12
        end else begin
            sweep_active_o <= (state == ST_IDLE) ? (wr_start && mode_ok)
                                                 : !(dwell_done && last_point
                                                     && cyc_left == 16'h0000);
        end
    end

    // ------------------------------------------------------------
    // Status and errors
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_status <= 3'h0;
        end else if (!running && wr_start && mode_ok) begin
            run_status <= 3'h1;
        end else if (running && wr_stop) begin
            run_status <= 3'h4; // RL12 RL13
        end else if (dwell_done && last_point && cyc_left == 16'h0000) begin
            run_status <= 3'h2; // RL13
        end
    end

    // Errors stay until the next start written while idle, accepted or not, so they can be read afterwards
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_word <= 2'h0;
        end else if (!running && wr_start) begin
            err_word <= mode_ok ? 2'h0 : 2'h1; // RL1 RL14
        end else if (meas_tmo) begin
            err_word[ER_MEAS_BIT] <= 1'b1; // RL14
        end
    end

    // ------------------------------------------------------------
    // Result store: one bank per quantity, rewritten every cycle
    // ------------------------------------------------------------
    logic [1:0]       host_bank;
    csw_rkind_e       host_kind;

    assign res_wdata[0] = applied_v;
    assign res_wdata[1] = meas_take ? meas_i.current : 16'h0000;
    assign res_wdata[2] = meas_take ? meas_i.power : 16'h0000;

    always_comb begin
        host_kind = RK_REG;
        host_bank = 2'h0;
        host_idx  = IDX_W'(rd_addr_i - CURVE_BASE);
        if (rd_addr_i >= CURVE_BASE && rd_addr_i <= CURVE_LAST) begin
            host_kind = RK_CURVE;
        end else if (rd_addr_i >= RES_POW_BASE && rd_addr_i <= RES_LAST) begin
            host_kind = RK_RES;
            host_bank = 2'h2;
            host_idx  = IDX_W'(rd_addr_i - RES_POW_BASE);
        end else if (rd_addr_i >= RES_CURR_BASE && rd_addr_i < RES_POW_BASE) begin
            host_kind = RK_RES;
            host_bank = 2'h1;
            host_idx  = IDX_W'(rd_addr_i - RES_CURR_BASE);
        end else if (rd_addr_i >= RES_VOLT_BASE && rd_addr_i < RES_CURR_BASE) begin
            host_kind = RK_RES;
            host_idx  = IDX_W'(rd_addr_i - RES_VOLT_BASE);
        end
    end

    for (genvar b = 0; b < 3; b++) begin : g_res
        csw_word_mem #(.WIDTH(16), .DEPTH(POINTS), .AW(IDX_W)) u_res (
            .mclk_i  (mclk_i),
            .we_i    (meas_take || meas_tmo), // RL9 RL10
            .waddr_i (pt_idx),
            .wdata_i (res_wdata[b]),
            .raddr_i (host_idx),
            .rdata_o (res_rdata[b]) // RL15
        );
    end

    // ------------------------------------------------------------
    // Host read pipeline: decode, then select
    // ------------------------------------------------------------
    logic        rd_p1;
    logic        rd_ld;
    csw_rkind_e  rd_kind;
    logic [1:0]  rd_bank;
    logic [15:0] rd_reg;
    logic [15:0] next_reg;

    always_comb begin
        case (rd_addr_i)
            REG_MODE_SELECT:  next_reg = mode_sel;
            REG_START_STOP:   next_reg = running ? CMD_START : CMD_STOP;
            REG_RUN_STATUS:   next_reg = {13'h0000, run_status}; // RL13
            REG_ERROR_WORD:   next_reg = {14'h0000, err_word}; // RL14
            REG_DWELL_MS:     next_reg = dwell_ms;
            REG_FIRST_INDEX:  next_reg = range_first;
            REG_LAST_INDEX:   next_reg = range_last;
            REG_EXTRA_CYCLES: next_reg = extra_cycles;
            default:          next_reg = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_p1   <= 1'b0;
            rd_ld   <= 1'b0;
            rd_kind <= RK_REG;
            rd_bank <= 2'h0;
            rd_reg  <= 16'h0000;
        end else begin
            rd_p1   <= rd_en_i;
            // Curve array has no reset, so unloaded words are masked here
            rd_ld   <= loaded[host_idx]; // RL3
            rd_kind <= host_kind;
            rd_bank <= host_bank;
            rd_reg  <= next_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= 16'h0000;
        end else begin
            rd_valid_o <= rd_p1;
            if (rd_p1) begin
                case (rd_kind)
                    RK_CURVE: rd_data_o <= rd_ld ? curve_rdata : 16'h0000; // RL2 RL3
                    RK_RES:   rd_data_o <= res_rdata[rd_bank]; // RL15
                    default:  rd_data_o <= rd_reg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_apply_pulse;
        meas_req_o ##1 !meas_req_o;
    endsequence

    property p_mode_gate;
        !running && wr_start && !mode_ok |=> !sweep_active_o && err_word[ER_MODE_BIT];
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("start taken outside mode"); // RL1

    property p_zero_unloaded;
        state == ST_APPLY && !loaded[pt_idx] && !wr_stop |=> set_voltage_o == 16'h0000;
    endproperty
    a_zero_unloaded: assert property (p_zero_unloaded) else $error("unloaded point not zero"); // RL3

    property p_end_range;
        wr_en_i && wr_i.addr == REG_LAST_INDEX && (wr_i.data == 16'h0000
            || wr_i.data > POINTS_MAX) |=> $stable(range_last);
    endproperty
    a_end_range: assert property (p_end_range) else $error("bad end index taken"); // RL4

    property p_start_range;
        range_first >= 16'h0001 && range_first <= range_last;
    endproperty
    a_start_range: assert property (p_start_range) else $error("start above end"); // RL5

    property p_dwell_hold;
        state == ST_DWELL && ms_cnt != dwell_ms && !wr_stop |=> state == ST_DWELL;
    endproperty
    a_dwell_hold: assert property (p_dwell_hold) else $error("dwell cut short"); // RL7

    property p_meas_step;
        state == ST_APPLY && !wr_stop |=> s_apply_pulse;
    endproperty
    a_meas_step: assert property (p_meas_step) else $error("no single measure pulse"); // RL10

    property p_ascend;
        dwell_done && !last_point && !wr_stop |=> point == $past(point) + 16'h0001
            && state == ST_FETCH;
    endproperty
    a_ascend: assert property (p_ascend) else $error("point not advanced"); // RL16

    property p_wrap;
        dwell_done && last_point && cyc_left != 16'h0000 && !wr_stop
            |=> point == range_first ##2 state == ST_MEAS;
    endproperty
    a_wrap: assert property (p_wrap) else $error("cycle did not restart"); // RL8 RL16

    property p_finish;
        dwell_done && last_point && cyc_left == 16'h0000 && !wr_stop
            |=> !sweep_active_o && run_status[ST_DONE_BIT];
    endproperty
    a_finish: assert property (p_finish) else $error("run did not end"); // RL11 RL13

    property p_abort;
        running && wr_stop |=> state == ST_IDLE && !sweep_active_o && run_status[ST_ABRT_BIT];
    endproperty
    a_abort: assert property (p_abort) else $error("stop not immediate"); // RL12

endmodule

// *** verif/csw_meas_model.sv ***
`timescale 1ns/1ps
module csw_meas_model
    import csw_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Sweeper side
    input  wire logic        req_i,
    input  wire logic [15:0] volt_i,
    output logic             valid_o,
    output csw_meas_s        meas_o
);
    logic [15:0] n;
    logic [1:0]  dly;
    // Data differs per request so overwritten results are visible
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            n <= 16'h0000;
            dly <= 2'h0;
        end else if (req_i) begin
            n <= n + 16'h0001;
            dly <= 2'h2;
        end else if (dly != 2'h0) begin
            dly <= dly - 2'h1;
        end
    end
    // Outside the answer the lines toggle, never a stale value
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid_o <= 1'b0;
            meas_o <= '0;
        end else begin
            valid_o <= (dly == 2'h1);
            meas_o <= (dly == 2'h1) ? {volt_i + n, n} : ~meas_o;
        end
    end
endmodule

// *** verif/tb_csw_sweeper.sv ***
`timescale 1ns/1ps
module tb_csw_sweeper;
    import csw_pkg::*;
    logic        mclk_i, resetn_i, wr_en_i, rd_en_i, rd_valid_o;
    logic        meas_req_o, meas_valid_i, sweep_active_o;
    logic [15:0] rd_addr_i, rd_data_o, set_voltage_o;
    csw_wr_s     wr_i;
    csw_meas_s   meas_i;
    int          err_total = 0, cmp_count = 0, rq, cy;
    csw_sweeper #(.TICKS_MS_CYC(10)) u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .wr_en_i(wr_en_i), .wr_i(wr_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .set_voltage_o(set_voltage_o),
        .meas_req_o(meas_req_o), .meas_valid_i(meas_valid_i), .meas_i(meas_i),
        .sweep_active_o(sweep_active_o));
    csw_meas_model u_meas (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(meas_req_o),
        .volt_i(set_voltage_o), .valid_o(meas_valid_i), .meas_o(meas_i));
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    task automatic conclude;
        $display("errors %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk_i) {wr_en_i, wr_i} = {1'b1, a, d};
        @(negedge mclk_i) wr_en_i = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(negedge mclk_i) {rd_en_i, rd_addr_i} = {1'b1, a};
        @(negedge mclk_i) rd_en_i = 1'b0;
        for (int i = 0; i < 4 && rd_valid_o !== 1'b1; i++) @(negedge mclk_i);
        chk("valid", 16'h0001, {15'h0000, rd_valid_o});
        chk("read", e, rd_data_o);
    endtask
    // Runs one sweep to its end; point 2 holds 0a00, point 3 never loaded
    task automatic run;
        wr(REG_START_STOP, CMD_START);
        rq = 0;
        cy = 0;
        for (int i = 0; i < 3000 && sweep_active_o === 1'b1; i++) begin
            if (meas_req_o === 1'b1) begin
                chk("volt", rq[0] ? 16'h0000 : 16'h0a00, set_voltage_o);
                rq++;
            end
            cy++;
            @(negedge mclk_i);
        end
    endtask
    initial begin
        {resetn_i, wr_en_i, rd_en_i, wr_i, rd_addr_i} = '0;
        repeat (20) @(posedge mclk_i);
        @(negedge mclk_i) resetn_i = 1'b1;
        rd(REG_FIRST_INDEX, RST_FIRST);
        wr(REG_START_STOP, CMD_START);
        chk("nomode", 16'h0000, {15'h0000, sweep_active_o});
        rd(REG_ERROR_WORD, 16'h0001);
        wr(CURVE_BASE + 16'h0001, 16'h0123);
        rd(CURVE_BASE + 16'h0001, 16'h0000);
        wr(REG_MODE_SELECT, 16'h0001);
        wr(CURVE_BASE + 16'h0001, 16'h0a00);
        wr(REG_LAST_INDEX, 16'h0065);
        rd(REG_LAST_INDEX, RST_LAST);
        wr(REG_LAST_INDEX, 16'h0003);
        wr(REG_FIRST_INDEX, 16'h0004);
        rd(REG_FIRST_INDEX, RST_FIRST);
        wr(REG_FIRST_INDEX, 16'h0002);
        wr(REG_DWELL_MS, 16'h0001);
        wr(REG_EXTRA_CYCLES, 16'h0001);
        wr(REG_START_STOP, 16'h1234);
        chk("ignored", 16'h0000, {15'h0000, sweep_active_o});
        run();
        chk("points", 16'h0004, rq[15:0]);
        chk("long", 16'h0001, {15'h0000, cy >= 40 && cy < 3000});
        rd(REG_RUN_STATUS, 16'h0002);
        rd(REG_ERROR_WORD, 16'h0000);
        rd(RES_VOLT_BASE + 16'h0001, 16'h0a00);
        rd(RES_CURR_BASE + 16'h0001, 16'h0a03);
        rd(RES_POW_BASE + 16'h0002, 16'h0004);
        wr(REG_EXTRA_CYCLES, 16'h0000);
        wr(REG_START_STOP, CMD_START);
        rd(REG_RUN_STATUS, 16'h0001);
        wr(REG_START_STOP, CMD_STOP);
        chk("stop", 16'h0000, {15'h0000, sweep_active_o});
        rd(REG_RUN_STATUS, 16'h0004);
        run();
        chk("once", 16'h0002, rq[15:0]);
        conclude();
    end
    initial begin
        #3000000;
        err_total++;
        conclude();
    end
endmodule
